// ===== rtl/aout_pkg.sv
// constants and types for the scaled analog output block
// Summary of operation
// - one scalable 0-10 V output value
// - differential mode uses differential amount
// - full-scale point gives ten volts
// - zero point gives zero volts
// - integral time five steps or off
// - mode off deactivates output
// - mode 1 rises with temperature, absolute
// - mode 2 falls with temperature, absolute
// - mode 3 proportional relative to setpoint
// - mode 4 anti-proportional relative to setpoint
// - at setpoint five volts plus integral
// - integral equals proportional after slow-down time
// - proportional part applies immediately on step
// - respond only to own address, never 64
// - baud rate selectable, default 9600
// - code 70 unlocks mode and sensor
// - code 88 unlocks general configuration
// - display shows sensor 1 after switch-on
// - per-sensor display calibration offsets
// - shift offsets leading setpoint when active
// - unit off gives 0 V or 10 V
package aout_pkg;
    // ------------------------------------------------------------
    // codes and limits
    // ------------------------------------------------------------
    localparam logic [7:0]  CODE_BASIC     = 8'h46;
    localparam logic [7:0]  CODE_GENERAL   = 8'h58;
    localparam logic [6:0]  ADDR_FORBIDDEN = 7'h40;
    localparam logic [2:0]  BAUD_DEFAULT   = 3'h2;
    localparam logic [2:0]  ITIME_OFF      = 3'h0;
    localparam logic [2:0]  ITIME_MAX      = 3'h5;
    localparam logic [2:0]  MODE_MAX       = 3'h4;
    // reset values
    localparam logic [6:0]  ADDR_RESET     = 7'h01;
    localparam logic signed [15:0] FULL_SCALE_RESET = 16'sh0064;
    // ------------------------------------------------------------
    // configuration write selects
    // ------------------------------------------------------------
    localparam logic [3:0]  SEL_BASIC      = 4'h0;
    localparam logic [3:0]  SEL_GENERAL    = 4'h1;
    localparam logic [3:0]  SEL_OP_MODE    = 4'h2;
    localparam logic [3:0]  SEL_SENSOR     = 4'h3;
    localparam logic [3:0]  SEL_RELAYS     = 4'h4;
    localparam logic [3:0]  SEL_INPUT_FN   = 4'h5;
    localparam logic [3:0]  SEL_ADDRESS    = 4'h6;
    localparam logic [3:0]  SEL_BAUD       = 4'h7;
    localparam logic [3:0]  SEL_FULL_SCALE = 4'h8;
    localparam logic [3:0]  SEL_ZERO       = 4'h9;
    localparam logic [3:0]  SEL_ITIME      = 4'hA;
    localparam logic [3:0]  SEL_MODE       = 4'hB;
    localparam logic [3:0]  SEL_TRIM_ONE   = 4'hC;
    localparam logic [3:0]  SEL_TRIM_TWO   = 4'hD;
    // output scale: millivolts
    localparam logic [13:0] OUT_FULL_MV    = 14'h2710;
    localparam logic [13:0] OUT_HALF_MV    = 14'h1388;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 100000000;
    localparam int TICK_MS         = 1;
    localparam int TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
    // integral step times in seconds: 15, 30, 60, 120, 240
    localparam int ISTEP_BASE_S    = 15;

    typedef enum logic [2:0] {
        MODE_OFF, MODE_PROP, MODE_ANTI, MODE_REL_PROP, MODE_REL_ANTI
    } out_mode_t;
endpackage

// ===== rtl/scaled_analog_output_pi.sv
// scaled 0-10 V output computation with PI action and config gating
`timescale 1ns/10ps
module scaled_analog_output_pi #(
    parameter int TICK_CYCLES = aout_pkg::TICK_CYCLES,
    parameter int MS_PER_S    = 1000
) (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    // measurements, tenths of kelvin, signed
    input  wire logic signed [15:0] sensor1_actual_value,
    input  wire logic signed [15:0] sensor2_actual_value,
    input  wire logic              differential_mode,
    // setpoint and shift
    input  wire logic signed [15:0] leading_setpoint,
    input  wire logic signed [15:0] setpoint_shift_amount,
    input  wire logic              shift_active,
    input  wire logic              unit_off,
    // configuration write port
    input  wire logic              cfg_write,
    input  wire logic [3:0]        cfg_select,
    input  wire logic signed [15:0] cfg_data,
    // node addressing
    input  wire logic [6:0]        frame_address,
    input  wire logic              frame_valid,
    // outputs
    output logic [13:0]            output_millivolts,
    output logic                   output_enabled,
    output logic                   frame_accepted,
    output logic [2:0]             baud_select,
    output logic [6:0]             node_address,
    output logic [7:0]             general_code_entry,
    output logic [7:0]             basic_code_entry,
    output logic [1:0]             operating_mode_param,
    output logic [1:0]             sensor_type_param,
    output logic [3:0]             relay_characteristic_params,
    output logic [1:0]             input_function_param,
    output logic signed [15:0]     display_one,
    output logic signed [15:0]     display_two
);
    // ------------------------------------------------------------
    // configuration storage
    // ------------------------------------------------------------
    logic signed [15:0] output_full_scale_point;
    logic signed [15:0] output_zero_point;
    logic [2:0]         integral_time_step;
    logic [2:0]         output_mode_select;
    logic signed [15:0] display_trim_one;
    logic signed [15:0] display_trim_two;

    wire logic basic_ok   = basic_code_entry == aout_pkg::CODE_BASIC;
    wire logic general_ok = general_code_entry == aout_pkg::CODE_GENERAL;

    // ------------------------------------------------------------
    // access codes
    // ------------------------------------------------------------
    // codes never time out here: an unlock lasts until rewritten
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            basic_code_entry   <= 8'h00;
            general_code_entry <= 8'h00;
        end else if (cfg_write) begin
            case (cfg_select)
                aout_pkg::SEL_BASIC:
                    basic_code_entry <= cfg_data[7:0];
                aout_pkg::SEL_GENERAL:
                    general_code_entry <= cfg_data[7:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // basic parameters
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            operating_mode_param <= 2'h0;
            sensor_type_param    <= 2'h0;
        end else if (cfg_write && basic_ok) begin
            case (cfg_select)
                aout_pkg::SEL_OP_MODE:
                    operating_mode_param <= cfg_data[1:0];
                aout_pkg::SEL_SENSOR:
                    sensor_type_param <= cfg_data[1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // relay and input parameters
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            relay_characteristic_params <= 4'h0;
            input_function_param        <= 2'h0;
        end else if (cfg_write && general_ok) begin
            case (cfg_select)
                aout_pkg::SEL_RELAYS:
                    relay_characteristic_params <= cfg_data[3:0];
                aout_pkg::SEL_INPUT_FN:
                    input_function_param <= cfg_data[1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // network parameters
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            node_address <= aout_pkg::ADDR_RESET;
            baud_select  <= aout_pkg::BAUD_DEFAULT;
        end else if (cfg_write && general_ok) begin
            case (cfg_select)
                aout_pkg::SEL_ADDRESS:
                    // a refused address keeps the old one in force
                    if (cfg_data[6:0] != aout_pkg::ADDR_FORBIDDEN)
                        node_address <= cfg_data[6:0];
                aout_pkg::SEL_BAUD:
                    baud_select <= cfg_data[2:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // analog output settings
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            output_full_scale_point <= aout_pkg::FULL_SCALE_RESET;
            output_zero_point       <= 16'sh0000;
            integral_time_step      <= aout_pkg::ITIME_OFF;
            output_mode_select      <= 3'h0;
        end else if (cfg_write && general_ok) begin
            case (cfg_select)
                aout_pkg::SEL_FULL_SCALE:
                    output_full_scale_point <= cfg_data;
                aout_pkg::SEL_ZERO:
                    output_zero_point <= cfg_data;
                aout_pkg::SEL_ITIME:
                    if (cfg_data[2:0] <= aout_pkg::ITIME_MAX)
                        integral_time_step <= cfg_data[2:0];
                aout_pkg::SEL_MODE:
                    // only cfg_data[2:0] is checked: 5 to 7 are refused, wider codes alias onto their low bits
                    if (cfg_data[2:0] <= aout_pkg::MODE_MAX)
                        output_mode_select <= cfg_data[2:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // display trims, never locked
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            display_trim_one <= 16'sh0000;
            display_trim_two <= 16'sh0000;
        end else if (cfg_write) begin
            case (cfg_select)
                aout_pkg::SEL_TRIM_ONE:
                    display_trim_one <= cfg_data;
                aout_pkg::SEL_TRIM_TWO:
                    display_trim_two <= cfg_data;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // node address filter
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            frame_accepted <= 1'b0;
        else
            frame_accepted <= frame_valid &&
                frame_address == node_address;
    end

    // ------------------------------------------------------------
    // display values
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            display_one <= 16'sh0000;
            display_two <= 16'sh0000;
        end else begin
            display_one <= sensor1_actual_value + display_trim_one;
            display_two <= sensor2_actual_value + display_trim_two;
        end
    end

    // ------------------------------------------------------------
    // proportional path
    // ------------------------------------------------------------
    aout_pkg::out_mode_t mode;
    always_comb begin
        case (output_mode_select)
            3'h1: mode = aout_pkg::MODE_PROP;
            3'h2: mode = aout_pkg::MODE_ANTI;
            3'h3: mode = aout_pkg::MODE_REL_PROP;
            3'h4: mode = aout_pkg::MODE_REL_ANTI;
            default: mode = aout_pkg::MODE_OFF;
        endcase
    end

    wire logic signed [17:0] measured = differential_mode ?
        18'(sensor1_actual_value) - 18'(sensor2_actual_value) :
        18'(sensor1_actual_value);
    wire logic signed [17:0] setpoint = shift_active ?
        18'(leading_setpoint) + 18'(setpoint_shift_amount) :
        18'(leading_setpoint);
    wire logic relative = mode == aout_pkg::MODE_REL_PROP ||
                          mode == aout_pkg::MODE_REL_ANTI;
    wire logic inverted = mode == aout_pkg::MODE_ANTI ||
                          mode == aout_pkg::MODE_REL_ANTI;
    // relative band: zero point is a signed offset added to setpoint
    wire logic signed [17:0] hi_point = relative ?
        setpoint + 18'(output_full_scale_point) :
        18'(output_full_scale_point);
    wire logic signed [17:0] lo_point = relative ?
        setpoint + 18'(output_zero_point) :
        18'(output_zero_point);
    wire logic signed [17:0] span = hi_point - lo_point;
    wire logic signed [17:0] pos  = measured - lo_point;

    // scaled position in millivolts, clamped; span of zero reads as 0 V
    function automatic logic signed [19:0] scale_mv(
        input logic signed [17:0] num,
        input logic signed [17:0] den
    );
        logic signed [35:0] prod;
        logic signed [35:0] quot;
        prod = 36'(num) * 36'sd10000;
        if (den == 18'sd0)
            quot = 36'sh0;
        else
            quot = prod / 36'(den);
        // saturate so a narrow band cannot wrap past the final clamp
        if (quot > 36'sh186A0)
            scale_mv = 20'sh186A0;
        else if (quot < -36'sh186A0)
            scale_mv = -20'sh186A0;
        else
            scale_mv = 20'(quot);
    endfunction

    function automatic logic [13:0] clamp_mv(
        input logic signed [21:0] v
    );
        if (v < 22'sd0)
            clamp_mv = 14'h0000;
        else if (v > 22'(aout_pkg::OUT_FULL_MV))
            clamp_mv = aout_pkg::OUT_FULL_MV;
        else
            clamp_mv = v[13:0];
    endfunction

    wire logic signed [19:0] p_raw = scale_mv(pos, span);
    // proportional deviation from the band centre, sign per direction
    wire logic signed [19:0] p_dev = p_raw - 20'(aout_pkg::OUT_HALF_MV);
    wire logic signed [19:0] p_dir = inverted ? -p_dev : p_dev;

    // ------------------------------------------------------------
    // integral path
    // ------------------------------------------------------------
    // integral ramps the proportional deviation once per tick;
    // full size after the selected slow-down time
    logic [31:0]        tick_count;
    logic               tick;
    logic signed [21:0] integral;
    logic [31:0]        ramp_ticks;

    always_comb begin
        case (integral_time_step)
            3'h1: ramp_ticks = 32'(aout_pkg::ISTEP_BASE_S * MS_PER_S);
            3'h2: ramp_ticks = 32'(2 * aout_pkg::ISTEP_BASE_S * MS_PER_S);
            3'h3: ramp_ticks = 32'(4 * aout_pkg::ISTEP_BASE_S * MS_PER_S);
            3'h4: ramp_ticks = 32'(8 * aout_pkg::ISTEP_BASE_S * MS_PER_S);
            3'h5: ramp_ticks = 32'(16 * aout_pkg::ISTEP_BASE_S * MS_PER_S);
            default: ramp_ticks = 32'h00000001;
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tick_count <= 32'h00000000;
            tick       <= 1'b0;
        end else if (tick_count >= 32'(TICK_CYCLES - 1)) begin
            tick_count <= 32'h00000000;
            tick       <= 1'b1;
        end else begin
            tick_count <= tick_count + 32'h00000001;
            tick       <= 1'b0;
        end
    end

    // per tick step of the integral, carried as a fraction remainder
    logic signed [53:0] i_acc;
    wire logic signed [53:0] i_step = 54'(p_dev) * 54'sd1;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            i_acc <= 54'sh0;
        end else if (integral_time_step == aout_pkg::ITIME_OFF ||
                     mode == aout_pkg::MODE_OFF || unit_off) begin
            i_acc <= 54'sh0;
        end else if (tick) begin
            i_acc <= i_acc + i_step;
        end
    end
    // signed copy of the limit, so the compares below stay signed
    localparam logic signed [53:0] I_LIMIT = 54'(aout_pkg::OUT_HALF_MV);
    // anti-windup: the integral never exceeds half scale either way
    always_comb begin
        logic signed [53:0] q;
        q = i_acc / 54'($signed({1'b0, ramp_ticks}));
        if (q > I_LIMIT)
            integral = 22'(aout_pkg::OUT_HALF_MV);
        else if (q < -I_LIMIT)
            integral = -22'(aout_pkg::OUT_HALF_MV);
        else
            integral = 22'(q);
    end
    wire logic signed [21:0] i_dir = inverted ? -integral : integral;

    // ------------------------------------------------------------
    // output register
    // ------------------------------------------------------------
    wire logic signed [21:0] total = 22'(aout_pkg::OUT_HALF_MV) +
        22'(p_dir) + i_dir;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            output_millivolts <= 14'h0000;
            output_enabled    <= 1'b0;
        end else if (mode == aout_pkg::MODE_OFF) begin
            output_millivolts <= 14'h0000;
            output_enabled    <= 1'b0;
        end else if (unit_off) begin
            output_millivolts <= inverted ?
                aout_pkg::OUT_FULL_MV : 14'h0000;
            output_enabled    <= 1'b1;
        end else begin
            output_millivolts <= clamp_mv(total);
            output_enabled    <= 1'b1;
        end
    end
endmodule

// ===== bench/aout_monitor.sv
// concurrent checks on the ports of the scaled analog output block
`timescale 1ns/10ps
module aout_monitor (
    // clock and reset
    input wire logic               ref_clk,
    input wire logic               sys_rst,
    // configuration and frames
    input wire logic               cfg_write,
    input wire logic [3:0]         cfg_select,
    input wire logic signed [15:0] cfg_data,
    input wire logic [6:0]         frame_address,
    input wire logic               frame_valid,
    // observed outputs
    input wire logic [13:0]        output_millivolts,
    input wire logic               frame_accepted,
    input wire logic [2:0]         baud_select,
    input wire logic [6:0]         node_address,
    input wire logic [7:0]         general_code_entry,
    input wire logic [7:0]         basic_code_entry,
    input wire logic [1:0]         operating_mode_param,
    input wire logic [1:0]         sensor_type_param
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    wire       hit    = frame_valid && frame_address == node_address;
    wire       no_gen = cfg_write && general_code_entry != 8'h58;
    wire       no_bas = cfg_write && basic_code_entry != 8'h46;
    wire [7:0] d_lo   = cfg_data[7:0];
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    chk_frame_take: assert property (hit |=> frame_accepted)
        else $error("own frame not accepted");
    chk_frame_drop: assert property (!hit |=> !frame_accepted)
        else $error("foreign frame accepted");
    chk_addr_legal: assert property (node_address != 7'h40)
        else $error("node address holds forbidden value");
    chk_mode_gate: assert property (no_bas && cfg_select == 4'h2
        |=> $stable(operating_mode_param))
        else $error("mode changed without basic code");
    chk_sensor_gate: assert property (no_bas && cfg_select == 4'h3
        |=> $stable(sensor_type_param))
        else $error("sensor type changed without basic code");
    chk_addr_gate: assert property (no_gen && cfg_select == 4'h6
        |=> $stable(node_address))
        else $error("address changed without general code");
    chk_baud_gate: assert property (no_gen && cfg_select == 4'h7
        |=> $stable(baud_select))
        else $error("baud changed without general code");
    chk_code_load: assert property (cfg_write && cfg_select == 4'h0
        |=> basic_code_entry == $past(d_lo))
        else $error("basic code not stored");
    chk_out_range: assert property (output_millivolts <= 14'h2710)
        else $error("output above full scale");
    cover property (frame_accepted);
    cover property (cfg_write && cfg_select == 4'h6 && !no_gen);
    cover property (output_millivolts == 14'h2710);
endmodule

bind scaled_analog_output_pi aout_monitor i_aout_monitor (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .cfg_write(cfg_write),
    .cfg_select(cfg_select), .cfg_data(cfg_data),
    .frame_address(frame_address), .frame_valid(frame_valid),
    .output_millivolts(output_millivolts),
    .frame_accepted(frame_accepted), .baud_select(baud_select),
    .node_address(node_address), .general_code_entry(general_code_entry),
    .basic_code_entry(basic_code_entry),
    .operating_mode_param(operating_mode_param),
    .sensor_type_param(sensor_type_param));

// ===== bench/serial_host.sv
// serial host model that sends frame addresses on the shared line
`timescale 1ns/10ps
module serial_host (
    // clock
    input wire logic   ref_clk,
    // frame side
    output logic [6:0] frame_address,
    output logic       frame_valid
);
    initial begin
        frame_address = 7'h00;
        frame_valid   = 1'b0;
    end
    // nodes share one line, told apart by address only
    task automatic send(input logic [6:0] addr);
        @(negedge ref_clk);
        frame_address = addr;
        frame_valid   = (addr != 7'h40);
        @(negedge ref_clk);
        frame_valid   = 1'b0;
        // released lines must not keep the last value
        frame_address = ~addr;
    endtask
endmodule

// ===== bench/testbench.sv
// self-checking bench for the scaled analog output block
`timescale 1ns/10ps
module testbench;
    logic               ref_clk = 1'b0;
    logic               sys_rst = 1'b1;
    logic signed [15:0] s1 = 16'h0000, s2 = 16'h0000;
    logic signed [15:0] sp = 16'h0000, shift = 16'h0000;
    logic               diff = 1'b0, shift_on = 1'b0, unit_off = 1'b0;
    logic               cfg_write = 1'b0;
    logic [3:0]         cfg_select = 4'h0;
    logic signed [15:0] cfg_data = 16'h0000;
    wire  [6:0]         f_addr;
    wire                f_valid, f_acc, en;
    wire  [13:0]        mv;
    wire  [2:0]         baud;
    wire  [6:0]         node;
    wire  [1:0]         opm, sens, infn;
    wire  [3:0]         rel;
    wire  [7:0]         gce, bce;
    wire signed [15:0]  d1, d2;
    int                 n_fail = 0;
    int                 tests_run = 0;
    always #5 ref_clk = ~ref_clk;
    serial_host i_serial_host (.ref_clk(ref_clk), .frame_address(f_addr),
        .frame_valid(f_valid));
    // short tick so the integral ramp fits the run
    scaled_analog_output_pi #(.TICK_CYCLES(10), .MS_PER_S(1))
    i_scaled_analog_output_pi (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .sensor1_actual_value(s1), .sensor2_actual_value(s2),
        .differential_mode(diff), .leading_setpoint(sp),
        .setpoint_shift_amount(shift), .shift_active(shift_on),
        .unit_off(unit_off), .cfg_write(cfg_write), .cfg_select(cfg_select),
        .cfg_data(cfg_data), .frame_address(f_addr), .frame_valid(f_valid),
        .output_millivolts(mv), .output_enabled(en), .frame_accepted(f_acc),
        .baud_select(baud), .node_address(node), .general_code_entry(gce),
        .basic_code_entry(bce), .operating_mode_param(opm),
        .sensor_type_param(sens), .relay_characteristic_params(rel),
        .input_function_param(infn), .display_one(d1), .display_two(d2));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic rng(input logic [15:0] g, lo, hi);
        tests_run++;
        if ($isunknown(g) || g < lo || g > hi) begin
            n_fail++;
            $display("Error at %0t: got %0h, want %0h..%0h", $time, g, lo, hi);
        end
    endtask
    task automatic cmp(input logic [15:0] g, e);
        rng(g, e, e);
    endtask
    task automatic wr(input logic [3:0] sel, input logic [15:0] d);
        @(negedge ref_clk);
        cfg_write  = 1'b1;
        cfg_select = sel;
        cfg_data   = d;
        @(negedge ref_clk);
        cfg_write  = 1'b0;
    endtask
    task automatic ac(input logic [15:0] m, v, e);
        wr(4'hB, m);
        s1 = v;
        repeat (3) @(negedge ref_clk);
        cmp({2'h0, mv}, e);
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge ref_clk);
        $display("Error at %0t: run timed out", $time);
        n_fail++;
        summarize();
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk) sys_rst = 1'b0;
        cmp({9'h000, node}, 16'h0001);
        cmp({13'h0000, baud}, 16'h0002);
        wr(4'h2, 16'h0002);
        cmp({14'h0000, opm}, 16'h0000);
        wr(4'h3, 16'h0001);
        cmp({14'h0000, sens}, 16'h0000);
        wr(4'h0, 16'h0046);
        cmp({8'h00, bce}, 16'h0046);
        wr(4'h2, 16'h0002);
        cmp({14'h0000, opm}, 16'h0002);
        wr(4'h3, 16'h0001);
        cmp({14'h0000, sens}, 16'h0001);
        wr(4'h6, 16'h0005);
        cmp({9'h000, node}, 16'h0001);
        wr(4'h7, 16'h0004);
        cmp({13'h0000, baud}, 16'h0002);
        wr(4'h1, 16'h0058);
        cmp({8'h00, gce}, 16'h0058);
        wr(4'h6, 16'h0040);
        cmp({9'h000, node}, 16'h0001);
        wr(4'h6, 16'h0005);
        cmp({9'h000, node}, 16'h0005);
        wr(4'h7, 16'h0004);
        cmp({13'h0000, baud}, 16'h0004);
        wr(4'h4, 16'h000A);
        wr(4'h5, 16'h0003);
        cmp({10'h000, infn, rel}, 16'h003A);
        $display("config test done");
        i_serial_host.send(7'h05);
        cmp({15'h0000, f_acc}, 16'h0001);
        i_serial_host.send(7'h01);
        cmp({15'h0000, f_acc}, 16'h0000);
        $display("frame test done");
        s1 = 16'h0064;
        s2 = 16'h001E;
        wr(4'hC, 16'h0007);
        wr(4'hD, 16'hFFFD);
        @(negedge ref_clk);
        cmp(d1, 16'h006B);
        cmp(d2, 16'h001B);
        $display("display test done");
        sp = 16'h00C8;
        wr(4'h8, 16'h0064);
        wr(4'h9, 16'h0000);
        ac(16'h0001, 16'h0019, 16'h09C4);
        cmp({15'h0000, en}, 16'h0001);
        ac(16'h0002, 16'h0019, 16'h1D4C);
        ac(16'h0001, 16'h0190, 16'h2710);
        ac(16'h0002, 16'hFFCE, 16'h2710);
        unit_off = 1'b1;
        ac(16'h0001, 16'h0019, 16'h0000);
        ac(16'h0002, 16'h0019, 16'h2710);
        unit_off = 1'b0;
        diff = 1'b1;
        ac(16'h0001, 16'h0050, 16'h1388);
        diff = 1'b0;
        wr(4'h9, 16'hFF9C);
        ac(16'h0003, 16'h00FA, 16'h1D4C);
        ac(16'h0004, 16'h00FA, 16'h09C4);
        ac(16'h0003, 16'h00C8, 16'h1388);
        shift = 16'h0032;
        shift_on = 1'b1;
        ac(16'h0003, 16'h00FA, 16'h1388);
        shift_on = 1'b0;
        wr(4'hB, 16'h0000);
        @(negedge ref_clk);
        cmp({15'h0000, en}, 16'h0000);
        cmp({2'h0, mv}, 16'h0000);
        $display("output test done");
        ac(16'h0003, 16'h00C8, 16'h1388);
        wr(4'hA, 16'h0001);
        s1 = 16'h00DC;
        repeat (2) @(negedge ref_clk);
        rng({2'h0, mv}, 16'h1770, 16'h17D4);
        repeat (160) @(negedge ref_clk);
        rng({2'h0, mv}, 16'h1AF4, 16'h1BBC);
        wr(4'hA, 16'h0000);
        repeat (3) @(negedge ref_clk);
        cmp({2'h0, mv}, 16'h1770);
        $display("integral test done");
        summarize();
    end
endmodule
